// >>> hw/srpc_pkg.sv
// Shared constants, field layouts and carrier types of the sensor reset and PLL register bank.
package srpc_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Bus geometry.

   localparam int          DATA_W  = 32;      // Wishbone data width.
   localparam int          REG_W   = 16;      // Width of every register word.
   localparam int          ADR_W   = 8;       // Byte address width on the bus.
   localparam int          IDX_W   = 6;       // Width of a register index.
   localparam int          IDX_LSB = 2;       // Index sits above the byte-in-word bits.

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register indices; the byte address is four times the index.

   localparam logic [5:0]  IDX_IDENTITY  = 6'h00;  // Identification word.
   localparam logic [5:0]  IDX_RSVD_A    = 6'h01;  // Reserved, reads zero.
   localparam logic [5:0]  IDX_VARIANT   = 6'h02;  // Product variant selector.
   localparam logic [5:0]  IDX_PLL_RST   = 6'h08;  // PLL and lock detector resets.
   localparam logic [5:0]  IDX_CGEN_RST  = 6'h09;  // Clock generator reset.
   localparam logic [5:0]  IDX_ANA_RST   = 6'h0a;  // Mux, front end and serializer resets.
   localparam logic [5:0]  IDX_PLL_PWR   = 6'h10;  // PLL power, enable and bypass.
   localparam logic [5:0]  IDX_PLL_DIV   = 6'h11;  // PLL dividers.
   localparam logic [5:0]  IDX_PAD       = 6'h14;  // Clock input pad settings.
   localparam logic [5:0]  IDX_LOCK      = 6'h18;  // PLL lock status.
   localparam logic [5:0]  IDX_RSVD_B    = 6'h1a;  // Reserved read-write word.
   localparam logic [5:0]  IDX_CLK_SRC   = 6'h20;  // Clock generator source select.

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Field layouts and reset values.

   localparam int          FIELD_W       = 4;      // Width of a soft reset field.
   localparam logic [3:0]  HOLD_CODE     = 4'h9;   // Field code that holds a block in reset.
   localparam int          NUM_RST       = 6;      // Soft reset fields in total.
   localparam logic [1:0]  RST_VARIANT   = 2'h0;
   localparam logic [7:0]  RST_PLL_RST   = 8'h99;
   localparam logic [3:0]  RST_CGEN_RST  = 4'h9;
   localparam logic [11:0] RST_ANA_RST   = 12'h999;
   localparam logic [2:0]  RST_PLL_PWR   = 3'h4;
   localparam logic [14:0] RST_PLL_DIV   = 15'h2113;
   localparam logic        RST_PAD       = 1'h0;
   localparam logic [14:0] RST_RSVD_B    = 15'h2280;
   localparam logic        RST_CLK_SRC   = 1'h1;
   localparam int          PWR_ON_BIT    = 0;      // PLL power bit.
   localparam int          PLL_EN_BIT    = 1;      // PLL enable bit.
   localparam int          BYPASS_BIT    = 2;      // PLL bypass bit.
   localparam int          MDIV_LSB      = 0;      // M divider, eight bits.
   localparam int          NDIV_LSB      = 8;      // N divider, five bits.
   localparam int          PDIV_LSB      = 13;     // P divider, two bits.
   localparam int          CLK_SRC_BIT   = 2;      // Clock source select bit.

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Carrier types.

   // PLL control fields as driven to the analog PLL.
   typedef struct packed {
      logic       pwr_on;
      logic       enable;
      logic       bypass;
      logic [7:0] mdiv;
      logic [4:0] ndiv;
      logic [1:0] pdiv;
   } srpc_pll_s;

   // Soft reset holds, one per block, high while the block is held.
   typedef struct packed {
      logic pll;
      logic lock_det;
      logic cgen;
      logic mux;
      logic afe;
      logic ser;
   } srpc_rst_s;

   // True while a soft reset field carries the hold code.
   function automatic logic srpc_in_reset(input logic [3:0] field);
      return field == HOLD_CODE;
   endfunction

endpackage

// >>> hw/srpc_regs.sv
// Sensor reset and PLL configuration register bank behind a classic Wishbone slave.
`timescale 1ns/100ps
module srpc_regs
   import srpc_pkg::*;
#(
   parameter logic [15:0] PART_ID = 16'h1e3c   // Identification value, arbitrary.
)
(
   input  wire logic              clk_i,           // System clock, 100 MHz.
   input  wire logic              rst_i,           // Synchronous reset, active high.
   input  wire logic              wb_cyc_i,        // Wishbone cycle.
   input  wire logic              wb_stb_i,        // Wishbone strobe.
   input  wire logic              wb_we_i,         // Wishbone write enable.
   input  wire logic [ADR_W-1:0]  wb_adr_i,        // Wishbone byte address.
   input  wire logic [3:0]        wb_sel_i,        // Wishbone byte enables.
   input  wire logic [DATA_W-1:0] wb_dat_i,        // Wishbone write data.
   output logic      [DATA_W-1:0] wb_dat_o,        // Wishbone read data.
   output logic                   wb_ack_o,        // Wishbone acknowledge.
   output logic                   wb_err_o,        // Wishbone error, unmapped address.
   input  wire logic              pll_lock_i,      // Lock level from the PLL.
   output logic      [1:0]        variant_o,       // Selected product variant.
   output srpc_rst_s              soft_rst_o,      // Soft reset holds per block.
   output srpc_pll_s              pll_o,           // PLL controls.
   output logic                   clk_in_pwd_n_o,  // Clock input buffer on when high.
   output logic                   clk_src_pll_o    // Clock generator runs from the PLL.
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Storage.

   logic [1:0]  variant;     // Product variant code.
   logic [7:0]  pll_rst;     // Lock detector field over PLL field.
   logic [3:0]  cgen_rst;    // Clock generator field.
   logic [11:0] ana_rst;     // Serializer, front end and mux fields.
   logic [2:0]  pll_pwr;     // Bypass, enable and power bits.
   logic [14:0] pll_div;     // P, N and M dividers.
   logic        pad_pwd_n;   // Clock input buffer power bit.
   logic [14:0] rsvd_b;      // Reserved read-write bits.
   logic        clk_src;     // Clock source select.
   logic        lock_stat;   // Registered lock indication.

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Bus decode.

   logic [IDX_W-1:0] idx;        // Register index of the request.
   logic             req;        // A request is on the bus.
   logic             new_req;    // A request not yet answered.
   logic             hit;        // The index names a register.
   logic             commit;     // A write lands in this cycle.
   logic [15:0]      rd_word;    // Current content of the addressed register.
   logic [15:0]      wr_word;    // Addressed register after byte-lane merge.

   // The index sits above the two byte-in-word bits.
   assign idx     = wb_adr_i[IDX_LSB +: IDX_W];
   assign req     = wb_cyc_i & wb_stb_i;

   // A request is answered once; the answer cycle does not start another.
   assign new_req = req & ~wb_ack_o & ~wb_err_o;

   // Writes take effect at the edge where the master sees the acknowledge.
   assign commit  = req & wb_we_i & wb_ack_o;

   // Only the listed indices answer with an acknowledge.
   assign hit = (idx == IDX_IDENTITY)
              | (idx == IDX_RSVD_A)
              | (idx == IDX_VARIANT)
              | (idx == IDX_PLL_RST)
              | (idx == IDX_CGEN_RST)
              | (idx == IDX_ANA_RST)
              | (idx == IDX_PLL_PWR)
              | (idx == IDX_PLL_DIV)
              | (idx == IDX_PAD)
              | (idx == IDX_LOCK)
              | (idx == IDX_RSVD_B)
              | (idx == IDX_CLK_SRC);

   // Read selection; unused bits of each word read as zero.
   assign rd_word =
        (idx == IDX_IDENTITY) ? PART_ID
      : (idx == IDX_VARIANT)  ? {14'h0000, variant}
      : (idx == IDX_PLL_RST)  ? {8'h00, pll_rst}
      : (idx == IDX_CGEN_RST) ? {12'h000, cgen_rst}
      : (idx == IDX_ANA_RST)  ? {4'h0, ana_rst}
      : (idx == IDX_PLL_PWR)  ? {13'h0000, pll_pwr}
      : (idx == IDX_PLL_DIV)  ? {1'b0, pll_div}
      : (idx == IDX_PAD)      ? {15'h0000, pad_pwd_n}
      : (idx == IDX_LOCK)     ? {15'h0000, lock_stat}
      : (idx == IDX_RSVD_B)   ? {1'b0, rsvd_b}
      : (idx == IDX_CLK_SRC)  ? {13'h0000, clk_src, 2'h0}
      : 16'h0000;

   // Byte lanes that are not selected keep their old content.
   assign wr_word = {wb_sel_i[1] ? wb_dat_i[15:8] : rd_word[15:8],
                     wb_sel_i[0] ? wb_dat_i[7:0]  : rd_word[7:0]};

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Bus answer.

   // Answer one cycle after the request, then drop for a cycle.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= '0;
      end
      else if (new_req)
      begin
         // Mapped indices acknowledge, others report an error.
         wb_ack_o <= hit;
         wb_err_o <= ~hit;
         wb_dat_o <= {16'h0000, rd_word};
      end
      else
      begin
         // The answer stands for exactly one cycle.
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Product and soft reset registers.

   // Variant selector; software programs the fitted variant.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         variant <= RST_VARIANT;
      else if (commit && idx == IDX_VARIANT)
         variant <= wr_word[1:0];
   end

   // PLL and lock detector reset fields; both come out of reset holding.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pll_rst <= RST_PLL_RST;
      else if (commit && idx == IDX_PLL_RST)
         pll_rst <= wr_word[7:0];
   end

   // Clock generator reset field.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cgen_rst <= RST_CGEN_RST;
      else if (commit && idx == IDX_CGEN_RST)
         cgen_rst <= wr_word[3:0];
   end

   // Analog chain reset fields, all three holding after reset.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ana_rst <= RST_ANA_RST;
      else if (commit && idx == IDX_ANA_RST)
         ana_rst <= wr_word[11:0];
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // PLL, pad and clock source registers.

   // PLL power, enable and bypass; bypassed and off after reset.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pll_pwr <= RST_PLL_PWR;
      else if (commit && idx == IDX_PLL_PWR)
         pll_pwr <= wr_word[2:0];
   end

   // PLL dividers.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pll_div <= RST_PLL_DIV;
      else if (commit && idx == IDX_PLL_DIV)
         pll_div <= wr_word[14:0];
   end

   // Clock input buffer power bit.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pad_pwd_n <= RST_PAD;
      else if (commit && idx == IDX_PAD)
         pad_pwd_n <= wr_word[0];
   end

   // Reserved word that software may write and read back.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rsvd_b <= RST_RSVD_B;
      else if (commit && idx == IDX_RSVD_B)
         rsvd_b <= wr_word[14:0];
   end

   // Clock source select; the PLL output is chosen after reset.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         clk_src <= RST_CLK_SRC;
      else if (commit && idx == IDX_CLK_SRC)
         clk_src <= wr_word[CLK_SRC_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Soft reset decode.

   logic [NUM_RST-1:0] hold;   // Decoded holds, field order as packed below.

   // Fields are packed PLL first, serializer last.
   srpc_rst_decode #(
      .N        (NUM_RST)
   ) u_decode (
      .fields_i ({ana_rst[11:8], ana_rst[7:4], ana_rst[3:0],
                  cgen_rst, pll_rst[7:4], pll_rst[3:0]}),
      .hold_o   (hold)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Lock indication.

   logic lock_sync;   // PLL lock level in this clock domain.

   // The lock level comes from the analog PLL, outside this domain.
   srpc_sync u_lock_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (pll_lock_i),
      .sync_o  (lock_sync)
   );

   // Lock reads one only while the detector runs and the PLL is up and active.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         lock_stat <= 1'b0;
      else
         lock_stat <= lock_sync & ~hold[1] & ~hold[0]
                    & pll_pwr[PWR_ON_BIT] & pll_pwr[PLL_EN_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Registered outputs.

   // Outputs follow the registers one cycle later, from flip-flops.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         variant_o      <= RST_VARIANT;
         soft_rst_o     <= '1;
         pll_o          <= '{pwr_on: RST_PLL_PWR[PWR_ON_BIT],
                             enable: RST_PLL_PWR[PLL_EN_BIT],
                             bypass: RST_PLL_PWR[BYPASS_BIT],
                             mdiv:   RST_PLL_DIV[MDIV_LSB +: 8],
                             ndiv:   RST_PLL_DIV[NDIV_LSB +: 5],
                             pdiv:   RST_PLL_DIV[PDIV_LSB +: 2]};
         clk_in_pwd_n_o <= RST_PAD;
         clk_src_pll_o  <= RST_CLK_SRC;
      end
      else
      begin
         variant_o           <= variant;

         // Holds follow the decoded fields.
         soft_rst_o.pll      <= hold[0];
         soft_rst_o.lock_det <= hold[1];
         soft_rst_o.cgen     <= hold[2];
         soft_rst_o.mux      <= hold[3];
         soft_rst_o.afe      <= hold[4];
         soft_rst_o.ser      <= hold[5];

         // PLL power, enable, bypass and dividers.
         pll_o.pwr_on        <= pll_pwr[PWR_ON_BIT];
         pll_o.enable        <= pll_pwr[PLL_EN_BIT];
         pll_o.bypass        <= pll_pwr[BYPASS_BIT];
         pll_o.mdiv          <= pll_div[MDIV_LSB +: 8];
         pll_o.ndiv          <= pll_div[NDIV_LSB +: 5];
         pll_o.pdiv          <= pll_div[PDIV_LSB +: 2];

         // Pad power and clock source.
         clk_in_pwd_n_o      <= pad_pwd_n;
         clk_src_pll_o       <= clk_src;
      end
   end

endmodule

// >>> hw/srpc_rst_decode.sv
// Decoder that turns four-bit soft reset fields into hold levels.
`timescale 1ns/100ps
module srpc_rst_decode
   import srpc_pkg::*;
#(
   parameter int N = NUM_RST                  // Number of fields.
)
(
   input  wire logic [N*FIELD_W-1:0] fields_i,  // Packed reset fields, field 0 lowest.
   output logic      [N-1:0]         hold_o     // High while the matching field holds.
);

   // Refuse a field count that the logic cannot serve.
   if (N < 1)
   begin : g_bad_n
      $error("Field count must be at least one.");
   end

   // Each field is decoded on its own; only the hold code holds.
   for (genvar i = 0; i < N; i++)
   begin : g_field
      assign hold_o[i] = srpc_in_reset(fields_i[i*FIELD_W +: FIELD_W]);
   end

endmodule

// >>> hw/srpc_sync.sv
// Two flip-flop synchroniser for a level that arrives from outside the clock domain.
`timescale 1ns/100ps
module srpc_sync
(
   input  wire logic clk_i,    // System clock.
   input  wire logic rst_i,    // Synchronous reset, active high.
   input  wire logic async_i,  // Level from another domain.
   output logic      sync_o    // Level safe to use in this domain.
);

   logic meta;  // First stage, read only by the second stage.

   // Two stages bring the level into the clock domain.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta   <= 1'b0;
         sync_o <= 1'b0;
      end
      else
      begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule

// >>> tb/srpc_regs_assertions.sv
// Concurrent checks on the ports of the sensor reset and PLL register bank.
`timescale 1ns/100ps
module srpc_regs_assertions
   import srpc_pkg::*;
#(
   parameter logic [15:0] PART_ID = 16'h1e3c   // Identification value, arbitrary.
)
(
   input  wire logic              clk_i,           // System clock.
   input  wire logic              rst_i,           // Synchronous reset.
   input  wire logic              wb_cyc_i,        // Wishbone cycle.
   input  wire logic              wb_stb_i,        // Wishbone strobe.
   input  wire logic              wb_we_i,         // Wishbone write enable.
   input  wire logic [ADR_W-1:0]  wb_adr_i,        // Wishbone byte address.
   input  wire logic [3:0]        wb_sel_i,        // Wishbone byte enables.
   input  wire logic [DATA_W-1:0] wb_dat_i,        // Wishbone write data.
   input  wire logic [DATA_W-1:0] wb_dat_o,        // Wishbone read data.
   input  wire logic              wb_ack_o,        // Wishbone acknowledge.
   input  wire logic              wb_err_o,        // Wishbone error.
   input  wire logic              pll_lock_i,      // Lock level from the PLL.
   input  wire logic [1:0]        variant_o,       // Selected variant.
   input  wire srpc_rst_s         soft_rst_o,      // Soft reset holds.
   input  wire srpc_pll_s         pll_o,           // PLL controls.
   input  wire logic              clk_in_pwd_n_o,  // Clock input buffer on.
   input  wire logic              clk_src_pll_o    // Clock source is the PLL.
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ////////////////////////////////////////////////////////////////
   // Answered requests, decoded once so the properties stay short.
   wire logic       rd_ack = wb_ack_o & ~wb_we_i;       // Read being answered.
   wire logic       lo_wr  = wb_ack_o & wb_we_i & wb_sel_i[0];  // Low lane written.
   wire logic [5:0] idx    = wb_adr_i[7:2];             // Register index.

   ////////////////////////////////////////////////////////////////
   // Properties; a write lands at the ack edge, outputs two edges later.
   property p_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o;
   endproperty
   property p_ident;
      rd_ack && idx == IDX_IDENTITY |-> wb_dat_o == {16'h0000, PART_ID};
   endproperty
   property p_variant;
      lo_wr && idx == IDX_VARIANT |-> ##2 variant_o == $past(wb_dat_i[1:0], 2);
   endproperty
   property p_pll_hold;
      lo_wr && idx == IDX_PLL_RST |-> ##2 soft_rst_o.pll == ($past(wb_dat_i[3:0], 2) == 4'h9);
   endproperty
   property p_lock_hold;
      lo_wr && idx == IDX_PLL_RST |-> ##2 soft_rst_o.lock_det == ($past(wb_dat_i[7:4], 2) == 4'h9);
   endproperty
   property p_cgen_hold;
      lo_wr && idx == IDX_CGEN_RST |-> ##2 soft_rst_o.cgen == ($past(wb_dat_i[3:0], 2) == 4'h9);
   endproperty
   property p_ana_hold;
      lo_wr && wb_sel_i[1] && idx == IDX_ANA_RST |-> ##2
         soft_rst_o.mux == ($past(wb_dat_i[3:0], 2) == 4'h9) &&
         soft_rst_o.afe == ($past(wb_dat_i[7:4], 2) == 4'h9) &&
         soft_rst_o.ser == ($past(wb_dat_i[11:8], 2) == 4'h9);
   endproperty
   property p_pll_ctl;
      lo_wr && idx == IDX_PLL_PWR |-> ##2
         {pll_o.bypass, pll_o.enable, pll_o.pwr_on} == $past(wb_dat_i[2:0], 2);
   endproperty
   property p_pad;
      lo_wr && idx == IDX_PAD |-> ##2 clk_in_pwd_n_o == $past(wb_dat_i[0], 2);
   endproperty
   property p_clk_src;
      lo_wr && idx == IDX_CLK_SRC |-> ##2 clk_src_pll_o == $past(wb_dat_i[2], 2);
   endproperty
   property p_lock;
      rd_ack && idx == IDX_LOCK && wb_dat_o[0] |->
         pll_o.pwr_on && pll_o.enable && !soft_rst_o.pll && !soft_rst_o.lock_det;
   endproperty
   property p_reset;
      disable iff (1'b0) rst_i |=> soft_rst_o == 6'h3f && variant_o == 2'h0 &&
         pll_o.bypass && !pll_o.pwr_on && !pll_o.enable && !clk_in_pwd_n_o;
   endproperty

   ////////////////////////////////////////////////////////////////
   // Assertions and covers.
   a_answer:    assert property (p_answer) else $error("request not answered in one cycle");
   a_ident:     assert property (p_ident) else $error("identity word wrong");
   a_variant:   assert property (p_variant) else $error("variant output wrong");
   a_pll_hold:  assert property (p_pll_hold) else $error("pll hold wrong");
   a_lock_hold: assert property (p_lock_hold) else $error("lock detector hold wrong");
   a_cgen_hold: assert property (p_cgen_hold) else $error("clock gen hold wrong");
   a_ana_hold:  assert property (p_ana_hold) else $error("analog holds wrong");
   a_pll_ctl:   assert property (p_pll_ctl) else $error("pll controls wrong");
   a_pad:       assert property (p_pad) else $error("clock input pad wrong");
   a_clk_src:   assert property (p_clk_src) else $error("clock source wrong");
   a_lock:      assert property (p_lock) else $error("lock shown while pll off");
   a_reset:     assert property (p_reset) else $error("reset values wrong");
   c_err:       cover property (wb_err_o);
   c_locked:    cover property (rd_ack && idx == IDX_LOCK && wb_dat_o[0]);
   c_release:   cover property ($fell(soft_rst_o.cgen));
endmodule

bind srpc_regs srpc_regs_assertions #(.PART_ID(PART_ID)) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pll_lock_i(pll_lock_i),
   .variant_o(variant_o), .soft_rst_o(soft_rst_o), .pll_o(pll_o),
   .clk_in_pwd_n_o(clk_in_pwd_n_o), .clk_src_pll_o(clk_src_pll_o));

// >>> tb/srpc_regs_bench.sv
// Self-checking bench for the sensor reset and PLL register bank.
`timescale 1ns/100ps
module srpc_regs_bench
   import srpc_pkg::*;
;
   localparam logic [15:0] ID_VAL = 16'h4b2d;  // Identification value, arbitrary.
   localparam logic [7:0]  RADR [12] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h24, 8'h28,
                                         8'h40, 8'h44, 8'h50, 8'h60, 8'h68, 8'h80};
   localparam logic [15:0] RVAL [12] = '{ID_VAL, 16'h0, 16'h0, 16'h0099, 16'h0009, 16'h0999,
                                         16'h0004, 16'h2113, 16'h0, 16'h0, 16'h2280, 16'h0004};
   logic              clk_i, rst_i;          // Clock and reset.
   logic              wb_cyc_i, wb_stb_i;    // Bus cycle and strobe.
   logic              wb_we_i;               // Bus direction.
   logic [ADR_W-1:0]  wb_adr_i;              // Bus address.
   logic [3:0]        wb_sel_i;              // Bus byte enables.
   logic [DATA_W-1:0] wb_dat_i, wb_dat_o;    // Bus data.
   logic              wb_ack_o, wb_err_o;    // Bus answers.
   logic              pll_lock_i;            // Lock level driven by the bench.
   logic [1:0]        variant_o;             // Variant seen.
   srpc_rst_s         soft_rst_o;            // Holds seen.
   srpc_pll_s         pll_o;                 // PLL controls seen.
   logic              clk_in_pwd_n_o;        // Pad control seen.
   logic              clk_src_pll_o;         // Clock source seen.
   int                bad_count, check_count;  // Mismatches and comparisons.
   logic [DATA_W-1:0] rd;                    // Last read data.
   logic              er;                    // Last error answer.

   srpc_regs #(.PART_ID(ID_VAL)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pll_lock_i(pll_lock_i),
      .variant_o(variant_o), .soft_rst_o(soft_rst_o), .pll_o(pll_o),
      .clk_in_pwd_n_o(clk_in_pwd_n_o), .clk_src_pll_o(clk_src_pll_o));

   // Free-running 100 MHz clock.
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////
   // Comparison, verdict and bus tasks.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // One classic cycle; entered just after a rising edge, leaves one idle cycle.
   task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] d);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
      begin
         bad_count++;
         results();
      end
      rd = wb_dat_o;
      er = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      bus(1'b1, adr, 4'h3, d);
   endtask

   task automatic rdchk(input logic [7:0] adr, input logic [15:0] exp);
      bus(1'b0, adr, 4'h3, 32'h0);
      check(rd, {16'h0000, exp});
   endtask

   ////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      logic [3:0] k;
      bad_count = 0;
      check_count = 0;
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      pll_lock_i = 1'b0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      @(negedge clk_i);
      check(32'(soft_rst_o), 32'h3f);
      check(32'(pll_o), 32'({3'h1, 8'h13, 5'h01, 2'h1}));
      @(posedge clk_i);
      for (int i = 0; i < 12; i++) rdchk(RADR[i], RVAL[i]);
      bus(1'b0, 8'h0c, 4'h3, 32'h0);
      check(32'(er), 32'h1);
      wr(8'h00, 32'hffff);
      wr(8'h60, 32'hffff);
      rdchk(8'h00, ID_VAL);
      rdchk(8'h60, 16'h0000);
      // Every code in every soft reset field, neighbours in a word offset; the PLL, clock generator and mux fields share each code.
      for (int c = 0; c < 16; c++)
      begin
         k = 4'(c);
         wr(8'h20, 32'({k ^ 4'h1, k}));
         wr(8'h24, 32'(k));
         wr(8'h28, 32'({k ^ 4'h2, k ^ 4'h1, k}));
         @(negedge clk_i);
         check(32'(soft_rst_o), 32'({k == 4'h9, (k ^ 4'h1) == 4'h9, k == 4'h9, k == 4'h9,
               (k ^ 4'h1) == 4'h9, (k ^ 4'h2) == 4'h9}));
         @(posedge clk_i);
      end
      bus(1'b1, 8'h28, 4'h2, 32'h0900);
      rdchk(8'h28, 16'h09ef);
      for (int v = 0; v < 8; v++)
      begin
         wr(8'h40, 32'(v));
         @(negedge clk_i);
         check(32'({pll_o.bypass, pll_o.enable, pll_o.pwr_on}), 32'(v));
         @(posedge clk_i);
      end
      for (int v = 0; v < 4; v++)
      begin
         wr(8'h08, 32'(v));
         rdchk(8'h08, 16'(v));
         check(32'(variant_o), 32'(v));
      end
      wr(8'h44, 32'hffff);
      rdchk(8'h44, 16'h7fff);
      // Distinct divider fields show whether each lands in its own output slot.
      wr(8'h44, 32'h4a5c);
      @(negedge clk_i);
      check(32'({pll_o.mdiv, pll_o.ndiv, pll_o.pdiv}), 32'({8'h5c, 5'h0a, 2'h2}));
      @(posedge clk_i);
      wr(8'h68, 32'hffff);
      rdchk(8'h68, 16'h7fff);
      wr(8'h50, 32'h1);
      wr(8'h80, 32'h0);
      rdchk(8'h80, 16'h0000);
      check(32'({clk_in_pwd_n_o, clk_src_pll_o}), 32'h2);
      wr(8'h80, 32'h4);
      wr(8'h50, 32'h0);
      rdchk(8'h80, 16'h0004);
      check(32'({clk_in_pwd_n_o, clk_src_pll_o}), 32'h1);
      // Lock shows while powered, enabled and out of both holds; the detector hold or a low input clears it.
      pll_lock_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rdchk(8'h60, 16'h0001);
      wr(8'h20, 32'h90);
      rdchk(8'h60, 16'h0000);
      wr(8'h20, 32'h00);
      pll_lock_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rdchk(8'h60, 16'h0000);
      // A second reset in mid-run restores the holds.
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdchk(8'h20, 16'h0099);
      check(32'(soft_rst_o), 32'h3f);
      results();
   end
endmodule
